// ### design/bit_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      count_q;
    wire              push = in_valid_i & in_ready_o;
    wire              pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = mem_q[rd_q];

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end else begin
            if (push) wr_q <= wrap_inc(wr_q);
            if (pop) rd_q <= wrap_inc(rd_q);
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ### design/tmc_cfg.svh
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH
`define CLK_PERIOD_NS      10
`define ON_UNIT_SHIFT      9
`define CONV_CYC           16
`define UPDATE_CYC         32
`define PEAK_RST_CYC       7
`define CAPTURE_MIN_CYC    32
`define SLOT_W             5
`define SYNC_W             6
`define SYNC_RST           6'h0C
`define PIN_HI             0
`define PIN_LO             1
`define PIN_CONF           2
`define PIN_SE             3
`define PIN_CAP            4
`define PIN_MOSI           5
`define DISCHARGE_CYC      4
`define TX_FIFO_DEPTH      8
`define TX_FIFO_WIDTH      1
`endif

// ### design/tmc_pkg.sv
package tmc_pkg;
    typedef enum logic [2:0] {
        st_standby,
        st_lvd,
        st_config,
        st_rx,
        st_tx
    } run_state_t;
endpackage

// ### design/transceiver_device.sv
// Functional notes
// RL1: oscillator mode: off and on both timed by clock
// RL2: on time is count times 512, after crystal
// RL3: off time N periods plus min(half, on)
// RL4: wake high forces receiver on, no pulldown
// RL5: host drives wake low before releasing it
// RL6: wake held low freezes off timer
// RL7: strength module only when enabled, else off
// RL8: log level low nibble, gain high nibble
// RL9: one converter, 16 cycles each, 32 update
// RL10: peak reset 7 cycles, hold follows capture
// RL11: sample mode freezes results after capture falls
// RL12: host holds capture at least 32 cycles
// RL13: continuous mode keeps converting and updating
// RL14: keying: mosi switches output stage
// RL15: frequency keying: mosi picks carrier
// RL16: single transmit state, mosi passed through
// RL17: no transmit output without pll lock
// RL18: standby: ignore everything until select lines low; code also waits for wake high before leaving
// RL19: standby plain or low-voltage-detect by enable
// RL20: leave standby only into configuration
// RL21: select low returns receive to configuration
// RL22: pins synchronised before use
`timescale 1ns/100ps
`default_nettype none
`include "tmc_cfg.svh"
module transceiver_device
    import tmc_pkg::*;
#(
    parameter int WAKE_PERIOD_CYC = 10000
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    trx_link.device         link,
    input  wire logic       tx_mode_i,
    input  wire logic       wake_osc_enable_i,
    input  wire logic [3:0] rx_on_count_i,
    input  wire logic [2:0] rx_off_code_i,
    input  wire logic       strength_enable_i,
    input  wire logic       strength_continuous_i,
    input  wire logic       modulation_select_i,
    input  wire logic       low_voltage_detect_enable_i,
    input  wire logic       xtal_started_i,
    input  wire logic       pll_lock_i,
    input  wire logic [3:0] log_level_i,
    input  wire logic [3:0] gain_level_i,
    output logic [2:0]      run_state_o,
    output logic            receiver_on_o,
    output logic            wake_pulldown_en_o,
    output logic            rf_stage_on_o,
    output logic            carrier_one_o,
    output logic            analog_strength_oe_o,
    output logic            peak_reset_switch_o,
    output logic            sample_hold_switch_o,
    output logic [7:0]      signal_strength_status_o
);
    // three stages; a change counts once stages two and three agree
    logic [`SYNC_W-1:0] s1_q;
    logic [`SYNC_W-1:0] s2_q;
    logic [`SYNC_W-1:0] s3_q;
    logic [`SYNC_W-1:0] pin_q;
    wire  [`SYNC_W-1:0] pin_raw = {link.mosi, link.strength_capture, link.serial_enable_n,
                                   link.config_select_n, link.wake_forced_low,
                                   link.wake_forced_high};

    function automatic logic [`SYNC_W-1:0] settle(input logic [`SYNC_W-1:0] a,
                                                 input logic [`SYNC_W-1:0] b,
                                                 input logic [`SYNC_W-1:0] old);
        settle = (~(a ^ b) & b) | ((a ^ b) & old);
    endfunction

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_q  <= `SYNC_RST;
            s2_q  <= `SYNC_RST;
            s3_q  <= `SYNC_RST;
            pin_q <= `SYNC_RST;
        end else begin
            s1_q  <= pin_raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= settle(s2_q, s3_q, pin_q); // see RL22
        end
    end

    wire wake_hi = pin_q[`PIN_HI];
    wire wake_lo = pin_q[`PIN_LO];
    wire conf_n  = pin_q[`PIN_CONF];
    wire se_n    = pin_q[`PIN_SE];
    wire capture = pin_q[`PIN_CAP];
    wire mosi    = pin_q[`PIN_MOSI];

    run_state_t state_q;
    run_state_t state_d;
    wire        standby_exit = ~conf_n & ~se_n & wake_hi; // see RL18 see RL20
    run_state_t idle_state;
    assign idle_state = low_voltage_detect_enable_i ? st_lvd : st_standby; // see RL19

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            st_standby,
            st_lvd: begin
                if (standby_exit) state_d = st_config; // see RL20
            end
            st_config: begin
                if (conf_n) begin
                    if (wake_lo) state_d = idle_state; // see RL18
                    else state_d = tx_mode_i ? st_tx : st_rx;
                end
            end
            st_rx: begin
                if (!conf_n) state_d = st_config; // see RL21
            end
            st_tx: begin
                if (!conf_n) state_d = st_config; // see RL16
            end
        endcase
    end

    // receiver duty cycle; counters stay wide so long off codes fit
    logic        rx_on_q;
    logic        rx_on_d;
    logic [31:0] on_cnt_q;
    logic [31:0] on_cnt_d;
    logic [31:0] off_cnt_q;
    logic [31:0] off_cnt_d;

    function automatic logic [31:0] off_periods(input logic [2:0] code);
        off_periods = 32'(code) + 32'h1;
    endfunction

    wire [31:0] on_target  = 32'(rx_on_count_i) << `ON_UNIT_SHIFT; // see RL2
    wire [31:0] half_per   = 32'(WAKE_PERIOD_CYC / 2);
    wire [31:0] off_extra  = (half_per < on_target) ? half_per : on_target;
    wire [31:0] off_target = off_periods(rx_off_code_i) * 32'(WAKE_PERIOD_CYC)
                             + off_extra; // see RL3
    wire        in_rx      = (state_q == st_rx);

    always_comb begin
        rx_on_d   = rx_on_q;
        on_cnt_d  = on_cnt_q;
        off_cnt_d = off_cnt_q;
        if (!in_rx) begin
            rx_on_d   = 1'b1;
            on_cnt_d  = '0;
            off_cnt_d = '0;
        end else if (wake_hi) begin
            rx_on_d   = 1'b1; // see RL4
            on_cnt_d  = '0;
            off_cnt_d = '0;
        end else if (!wake_osc_enable_i) begin
            rx_on_d = 1'b0;
        end else if (rx_on_q) begin
            // on time runs on the clock, only once the crystal is up
            if (xtal_started_i) on_cnt_d = on_cnt_q + 32'h1; // see RL1 see RL2
            if (xtal_started_i && on_cnt_d >= on_target) begin
                rx_on_d   = 1'b0;
                off_cnt_d = '0;
            end
        end else if (!wake_lo) begin
            off_cnt_d = off_cnt_q + 32'h1; // see RL1 see RL6
            if (off_cnt_d >= off_target) begin
                rx_on_d  = 1'b1;
                on_cnt_d = '0;
            end
        end
    end

    // strength module: one converter serves both levels in turn
    wire               strength_on = in_rx & strength_enable_i; // see RL7
    logic [2:0]        peak_cnt_q;
    logic              peak_done_q;
    wire               conv_run    = strength_on & peak_done_q
                                     & (strength_continuous_i | capture); // see RL11 see RL13
    logic [`SLOT_W-1:0] slot_q;
    logic [3:0]        log_hold_q;
    logic [7:0]        status_q;
    logic              rf_q;
    logic              carrier_q;
    wire               slot_log = (slot_q == `SLOT_W'(`CONV_CYC - 1));
    wire               slot_end = (slot_q == `SLOT_W'(`UPDATE_CYC - 1));

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q   <= st_standby;
            rx_on_q   <= 1'b0;
            on_cnt_q  <= '0;
            off_cnt_q <= '0;
        end else begin
            state_q   <= state_d;
            rx_on_q   <= rx_on_d;
            on_cnt_q  <= on_cnt_d;
            off_cnt_q <= off_cnt_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            peak_cnt_q  <= '0;
            peak_done_q <= 1'b0;
        end else if (!strength_on) begin
            peak_cnt_q  <= '0;
            peak_done_q <= 1'b0;
        end else if (!peak_done_q) begin
            peak_cnt_q  <= peak_cnt_q + 3'h1;
            peak_done_q <= (peak_cnt_q == 3'(`PEAK_RST_CYC - 1)); // see RL10
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            slot_q     <= '0;
            log_hold_q <= '0;
            status_q   <= '0;
        end else if (!conv_run) begin
            slot_q <= '0; // partial conversion dropped, last result kept
        end else begin
            slot_q <= slot_end ? '0 : slot_q + `SLOT_W'(1); // see RL9
            if (slot_log) log_hold_q <= log_level_i;
            if (slot_end) status_q <= {gain_level_i, log_hold_q}; // see RL8 see RL13
        end
    end

    // transmit: mosi goes straight to the modulator, lock gates it
    wire tx_ok = (state_q == st_tx) & pll_lock_i; // see RL17

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rf_q      <= 1'b0;
            carrier_q <= 1'b0;
        end else begin
            rf_q      <= tx_ok & (modulation_select_i | mosi); // see RL14 see RL16
            carrier_q <= tx_ok & modulation_select_i & mosi; // see RL15
        end
    end

    assign run_state_o              = state_q;
    assign receiver_on_o            = in_rx & rx_on_q;
    assign wake_pulldown_en_o       = ~(in_rx & wake_hi); // see RL4
    assign rf_stage_on_o            = rf_q;
    assign carrier_one_o            = carrier_q;
    assign analog_strength_oe_o     = strength_on; // see RL7
    assign peak_reset_switch_o      = strength_on & ~peak_done_q; // see RL10
    assign sample_hold_switch_o     = strength_on & peak_done_q & capture; // see RL10
    assign signal_strength_status_o = status_q;
endmodule
`default_nettype wire

// ### design/transceiver_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "tmc_cfg.svh"
module transceiver_host
    import tmc_pkg::*;
#(
    parameter int BIT_CYC = 500
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_b_i,
    trx_link.host     link,
    input  wire logic config_req_i,
    input  wire logic standby_req_i,
    input  wire logic wake_req_i,
    input  wire logic capture_req_i,
    input  wire logic tx_enable_i,
    input  wire logic tx_valid_i,
    input  wire logic tx_bit_i,
    output logic      tx_ready_o
);
    logic        conf_n_q;
    logic        se_n_q;
    logic        wake_out_q;
    logic        wake_oe_q;
    logic [2:0]  dis_q;
    logic        cap_q;
    logic [5:0]  cap_cnt_q;
    logic        mosi_q;
    logic [31:0] bit_cnt_q;
    logic        fifo_valid;
    logic        fifo_bit;
    wire         drive_hi = config_req_i | wake_req_i; // see RL20
    wire         bit_tick = tx_enable_i & (bit_cnt_q == '0);

    bit_fifo #(
        .WIDTH (`TX_FIFO_WIDTH),
        .DEPTH (`TX_FIFO_DEPTH)
    ) bit_fifo_i (
        .ref_clk_i   (ref_clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (tx_valid_i),
        .in_data_i   (tx_bit_i),
        .in_ready_o  (tx_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_bit),
        .out_ready_i (bit_tick)
    );

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conf_n_q   <= 1'b1;
            se_n_q     <= 1'b1;
            wake_out_q <= 1'b0;
            wake_oe_q  <= 1'b1;
            dis_q      <= '0;
        end else begin
            conf_n_q   <= ~config_req_i; // see RL18
            se_n_q     <= ~config_req_i;
            wake_oe_q  <= drive_hi | standby_req_i | (dis_q != '0);
            wake_out_q <= drive_hi;
            // discharge the timing capacitor before letting go
            if (drive_hi) dis_q <= 3'(`DISCHARGE_CYC); // see RL5
            else if (dis_q != '0) dis_q <= dis_q - 3'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cap_q     <= 1'b0;
            cap_cnt_q <= '0;
        end else if (capture_req_i) begin
            cap_q     <= 1'b1;
            cap_cnt_q <= '0;
        end else if (cap_q && cap_cnt_q < 6'(`CAPTURE_MIN_CYC - 1)) begin
            cap_cnt_q <= cap_cnt_q + 6'h1; // see RL12
        end else begin
            cap_q <= 1'b0;
        end
    end

    // an empty fifo sends zero, which is carrier off in keying mode
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_cnt_q <= '0;
            mosi_q    <= 1'b0;
        end else if (!tx_enable_i) begin
            bit_cnt_q <= '0;
            mosi_q    <= 1'b0;
        end else begin
            bit_cnt_q <= bit_tick ? 32'(BIT_CYC - 1) : bit_cnt_q - 32'h1;
            if (bit_tick) mosi_q <= fifo_valid & fifo_bit;
        end
    end

    assign link.config_select_n  = conf_n_q;
    assign link.serial_enable_n  = se_n_q;
    assign link.wake_out         = wake_out_q;
    assign link.wake_oe          = wake_oe_q;
    assign link.strength_capture = cap_q;
    assign link.mosi             = mosi_q;
endmodule
`default_nettype wire

// ### design/trx_link.sv
`timescale 1ns/100ps
`default_nettype none
interface trx_link;
    logic config_select_n;
    logic serial_enable_n;
    logic mosi;
    logic strength_capture;
    logic wake_out;
    logic wake_oe;
    wire  wake_forced_high = wake_oe & wake_out;
    wire  wake_forced_low  = wake_oe & ~wake_out;

    modport host (
        output config_select_n,
        output serial_enable_n,
        output mosi,
        output strength_capture,
        output wake_out,
        output wake_oe
    );
    modport device (
        input config_select_n,
        input serial_enable_n,
        input mosi,
        input strength_capture,
        input wake_forced_high,
        input wake_forced_low
    );
endinterface
`default_nettype wire

// ### verification/transceiver_mode_control_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module transceiver_mode_control_assertions
    import tmc_pkg::*;
(
    input wire logic       ref_clk_i,
    input wire logic       rst_b_i,
    input wire logic       config_select_n,
    input wire logic       wake_out,
    input wire logic       wake_oe,
    input wire logic       wake_forced_high,
    input wire logic [2:0] run_state_o,
    input wire logic       receiver_on_o,
    input wire logic       wake_pulldown_en_o,
    input wire logic       rf_stage_on_o,
    input wire logic       analog_strength_oe_o,
    input wire logic       peak_reset_switch_o,
    input wire logic       pll_lock_i,
    input wire logic       strength_enable_i
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    property p_release_low;
        $fell(wake_oe) |-> !$past(wake_out);
    endproperty
    a_release_low: assert property (p_release_low) else $error("wake released from high");
    property p_wake_on;
        (run_state_o == st_rx && wake_forced_high) [*6] |-> receiver_on_o && !wake_pulldown_en_o;
    endproperty
    a_wake_on: assert property (p_wake_on) else $error("wake high not forcing on");
    property p_lock;
        !pll_lock_i [*3] |-> !rf_stage_on_o;
    endproperty
    a_lock: assert property (p_lock) else $error("output stage on without lock");
    property p_strength_oe;
        analog_strength_oe_o == (run_state_o == st_rx && strength_enable_i);
    endproperty
    a_strength_oe: assert property (p_strength_oe) else $error("strength buffer enable");
    property p_tx_only;
        (run_state_o != st_tx) [*3] |-> !rf_stage_on_o;
    endproperty
    a_tx_only: assert property (p_tx_only) else $error("output stage on outside tx");
    property p_standby_hold;
        (run_state_o == st_standby && config_select_n) [*8] |=> run_state_o == st_standby;
    endproperty
    a_standby_hold: assert property (p_standby_hold) else $error("standby left");
    property p_peak_reset;
        $rose(peak_reset_switch_o) |-> peak_reset_switch_o [*7] ##1 !peak_reset_switch_o;
    endproperty
    a_peak_reset: assert property (p_peak_reset) else $error("peak reset length");
    property p_cfg_return;
        run_state_o == st_rx && !config_select_n |-> ##[1:8] run_state_o == st_config;
    endproperty
    a_cfg_return: assert property (p_cfg_return) else $error("no return to config");
endmodule
`default_nettype wire

// ### verification/transceiver_mode_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module transceiver_mode_control_test
    import tmc_pkg::*;
;
    typedef struct {
        logic       wake;
        logic       stby;
        logic       txm;
        logic       lvd;
        run_state_t st;
    } row_t;
    row_t       rows [4] = '{'{1'b1, 1'b0, 1'b0, 1'b0, st_rx}, '{1'b1, 1'b0, 1'b1, 1'b0, st_tx},
                             '{1'b0, 1'b1, 1'b0, 1'b0, st_standby},
                             '{1'b0, 1'b1, 1'b0, 1'b1, st_lvd}};
    logic       ref_clk_i = 1'b0, rst_b_i = 1'b0, config_req_i = 1'b0, standby_req_i = 1'b0;
    logic       wake_req_i = 1'b0, capture_req_i = 1'b0, tx_enable_i = 1'b0, tx_valid_i = 1'b0;
    logic       tx_bit_i = 1'b0, tx_mode_i = 1'b0, wake_osc_enable_i = 1'b1, pll_lock_i = 1'b1;
    logic       strength_enable_i = 1'b0, strength_continuous_i = 1'b1, xtal_started_i = 1'b1;
    logic       modulation_select_i = 1'b0, low_voltage_detect_enable_i = 1'b0;
    logic [3:0] rx_on_count_i = 4'h1, log_level_i = 4'h0, gain_level_i = 4'h0;
    logic [2:0] rx_off_code_i = 3'h0, run_state_o;
    logic [7:0] signal_strength_status_o;
    logic       tx_ready_o, receiver_on_o, wake_pulldown_en_o, rf_stage_on_o, carrier_one_o;
    logic       analog_strength_oe_o, peak_reset_switch_o, sample_hold_switch_o;
    int         num_errors = 0, checks_done = 0, n;
    trx_link trx_link_i ();
    transceiver_host #(.BIT_CYC(4)) transceiver_host_i (.ref_clk_i, .rst_b_i, .link(trx_link_i),
        .config_req_i, .standby_req_i, .wake_req_i, .capture_req_i, .tx_enable_i, .tx_valid_i,
        .tx_bit_i, .tx_ready_o);
    transceiver_device #(.WAKE_PERIOD_CYC(40)) transceiver_device_i (.ref_clk_i, .rst_b_i,
        .link(trx_link_i), .tx_mode_i, .wake_osc_enable_i, .rx_on_count_i, .rx_off_code_i,
        .strength_enable_i, .strength_continuous_i, .modulation_select_i,
        .low_voltage_detect_enable_i, .xtal_started_i, .pll_lock_i, .log_level_i, .gain_level_i,
        .run_state_o, .receiver_on_o, .wake_pulldown_en_o, .rf_stage_on_o, .carrier_one_o,
        .analog_strength_oe_o, .peak_reset_switch_o, .sample_hold_switch_o,
        .signal_strength_status_o);
    transceiver_mode_control_assertions transceiver_mode_control_assertions_i (.ref_clk_i,
        .rst_b_i, .config_select_n(trx_link_i.config_select_n), .wake_out(trx_link_i.wake_out),
        .wake_oe(trx_link_i.wake_oe), .wake_forced_high(trx_link_i.wake_forced_high),
        .run_state_o, .receiver_on_o, .wake_pulldown_en_o, .rf_stage_on_o,
        .analog_strength_oe_o, .peak_reset_switch_o, .pll_lock_i, .strength_enable_i);
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // inputs move 1 ns after the edge, never racing the design's sampling
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic go(input row_t r);
        config_req_i = 1'b1;
        wake_req_i = 1'b0;
        standby_req_i = 1'b0;
        cyc(20);
        chk(run_state_o === st_config, "config entry");
        wake_req_i = r.wake;
        standby_req_i = r.stby;
        tx_mode_i = r.txm;
        low_voltage_detect_enable_i = r.lvd;
        config_req_i = 1'b0;
        cyc(20);
        chk(run_state_o === r.st, "mode after config");
    endtask
    task automatic span(input logic lvl, output int k);
        k = 0;
        while (receiver_on_o === lvl && k < 3000) begin
            cyc(1);
            k++;
        end
        chk(k < 3000, "duty span limit");
    endtask
    // pushes with popping stopped, so the count shows the depth exactly
    task automatic fill(output int k);
        logic acc;
        k = 0;
        tx_enable_i = 1'b0;
        tx_valid_i = 1'b1;
        repeat (12) begin
            tx_bit_i = (k < 4);
            acc = tx_ready_o;
            cyc(1);
            if (acc) k++;
        end
        tx_valid_i = 1'b0;
    endtask
    task automatic stream(input logic m);
        int   s;
        logic p;
        s = 0;
        p = 1'b0;
        modulation_select_i = m;
        fill(n);
        chk(n == 8 && tx_ready_o === 1'b0, "fifo fill");
        tx_enable_i = 1'b1;
        repeat (80) begin
            cyc(1);
            s = (trx_link_i.mosi === p) ? s + 1 : 0;
            p = trx_link_i.mosi;
            if (s == 8) chk((m ? carrier_one_o : rf_stage_on_o) === p, "keyed out");
        end
        chk(tx_ready_o === 1'b1, "fifo drained");
    endtask
    task automatic results;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        cyc(6);
        rst_b_i = 1'b1;
        cyc(2);
        chk(run_state_o === st_standby && wake_pulldown_en_o === 1'b1, "reset state");
        chk(signal_strength_status_o === 8'h00 && tx_ready_o === 1'b1, "reset outputs");
        foreach (rows[i]) go(rows[i]);
        wake_req_i = 1'b1;
        capture_req_i = 1'b1;
        cyc(30);
        chk(run_state_o === st_lvd, "standby ignores pins");
        capture_req_i = 1'b0;
        go(rows[0]);
        wake_req_i = 1'b0;
        for (int c = 0; c < 8; c++) begin
            rx_off_code_i = c[2:0];
            span(1'b1, n);
            span(1'b0, n);
            chk(n >= (c + 1) * 40 + 19 && n <= (c + 1) * 40 + 21, "off time");
            xtal_started_i = 1'b0;
            cyc(100);
            xtal_started_i = 1'b1;
            span(1'b1, n);
            chk(n >= 510 && n <= 514, "on time");
        end
        rx_off_code_i = 3'h0;
        span(1'b0, n);
        span(1'b1, n);
        standby_req_i = 1'b1;
        cyc(100);
        chk(receiver_on_o === 1'b0, "off held by low wake");
        standby_req_i = 1'b0;
        wake_osc_enable_i = 1'b0;
        cyc(100);
        chk(receiver_on_o === 1'b0, "host strobe off");
        wake_req_i = 1'b1;
        cyc(8);
        chk(receiver_on_o === 1'b1 && wake_pulldown_en_o === 1'b0, "host strobe on");
        wake_osc_enable_i = 1'b1;
        log_level_i = 4'h5;
        gain_level_i = 4'hA;
        strength_enable_i = 1'b1;
        cyc(80);
        chk(signal_strength_status_o === 8'hA5, "status nibbles");
        log_level_i = 4'h3;
        gain_level_i = 4'hC;
        cyc(70);
        chk(signal_strength_status_o === 8'hC3, "status refresh");
        strength_continuous_i = 1'b0;
        log_level_i = 4'h6;
        gain_level_i = 4'h7;
        cyc(70);
        chk(signal_strength_status_o === 8'hC3, "sample mode idle");
        capture_req_i = 1'b1;
        cyc(1);
        capture_req_i = 1'b0;
        cyc(12);
        chk(sample_hold_switch_o === 1'b1, "hold closed");
        cyc(60);
        chk(!sample_hold_switch_o && signal_strength_status_o === 8'h76, "sampled");
        log_level_i = 4'h1;
        cyc(70);
        chk(signal_strength_status_o === 8'h76, "frozen after capture");
        strength_enable_i = 1'b0;
        cyc(2);
        chk(analog_strength_oe_o === 1'b0, "strength off");
        go(rows[1]);
        stream(1'b0);
        stream(1'b1);
        fill(n);
        tx_enable_i = 1'b1;
        cyc(14);
        pll_lock_i = 1'b0;
        cyc(3);
        chk(rf_stage_on_o === 1'b0, "lock lost");
        pll_lock_i = 1'b1;
        go(rows[2]);
        results();
    end
    // about 8.7k cycles expected; generous margin before cutting a hang
    initial begin
        #400000;
        num_errors++;
        $display("wrong value at %0t: timeout", $time);
        results();
    end
endmodule
`default_nettype wire
